// [hdl/fifo_cfg_pkg.sv]
package fifo_cfg_pkg;
    localparam int DATA_W = 18;
    localparam int DEPTH  = 256;
    localparam int OFS_W  = 12;

    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_AE     = 8'h04;
    localparam logic [7:0] OFF_AF     = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0C;
    localparam logic [7:0] OFF_COUNT  = 8'h10;

    localparam int CTRL_FLUSH_BIT = 0;
    localparam int STAT_MODE_LSB  = 0;
    localparam int STAT_EMPTY_BIT = 4;
    localparam int STAT_FULL_BIT  = 5;
    localparam int STAT_OUTV_BIT  = 6;
    localparam int STAT_WTOK_BIT  = 7;
    localparam int STAT_RTOK_BIT  = 8;

    localparam logic [OFS_W-1:0] AE_RESET = 12'h007;
    localparam logic [OFS_W-1:0] AF_RESET = 12'h007;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // strap order: {first_device_select, read_chain_in, write_chain_in}
    localparam logic [2:0] STRAP_STD_A   = 3'h0;
    localparam logic [2:0] STRAP_STD_B   = 3'h4;
    localparam logic [2:0] STRAP_FALL_A  = 3'h1;
    localparam logic [2:0] STRAP_FALL_B  = 3'h5;
    localparam logic [2:0] STRAP_DBL_A   = 3'h2;
    localparam logic [2:0] STRAP_DBL_B   = 3'h6;

    localparam logic [1:0] BOOT_CAPTURE = 2'h2;
    localparam logic [1:0] BOOT_DONE    = 2'h3;

    typedef enum logic [3:0] {
        MODE_STD   = 4'b0001,
        MODE_DBL   = 4'b0010,
        MODE_FALL  = 4'b0100,
        MODE_DAISY = 4'b1000
    } mode_t;
endpackage

// [hdl/sync_2ff.sv]
`timescale 1ns/10ps
module sync_2ff #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule

// [hdl/fifo_store.sv]
`timescale 1ns/10ps
module fifo_store #(
    parameter int W  = 18,
    parameter int D  = 256,
    parameter int AW = 8
) (
    input  wire logic          clk,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [W-1:0]  wdata,
    input  wire logic [AW-1:0] raddr,
    output logic      [W-1:0]  rdata
);
    // data storage only; pointers and counts live with the control logic
    logic [W-1:0] mem [D];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    assign rdata = mem[raddr];
endmodule

// [hdl/fifo_expansion_config.sv]
// Overview of operation
// - single-device modes from six strap codes at reset
// - buffers up to the full native depth
// - no half-full flag in daisy chain
// - chained almost flags are approximate thresholds
// - daisy: single-registered flags, asynchronous almost flags
// - fall-through outputs cascade directly, depths add
// - first word falls through without read request
// - word at outputs drives output ready low
// - ripple delay only for first word
// - freed location drives input ready low
// - straps 001 or 101 select fall-through mode
// - straps 010 or 110 select double-buffered flags
//
// The AXI4-Lite interface to the registers and the address map were left to the implementer.
`timescale 1ns/10ps
module fifo_expansion_config #(
    parameter int DATA_W = fifo_cfg_pkg::DATA_W,
    parameter int DEPTH  = fifo_cfg_pkg::DEPTH
) (
    input  wire logic              clk,
    input  wire logic              rstn,
    input  wire logic [7:0]        awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    input  wire logic [7:0]        araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    input  wire logic              write_clk,
    input  wire logic              write_enable_n,
    input  wire logic [DATA_W-1:0] data_in,
    input  wire logic              read_clk,
    input  wire logic              read_enable_n,
    output logic [DATA_W-1:0]      data_out,
    input  wire logic              first_device_select_n,
    input  wire logic              read_chain_in_n,
    input  wire logic              write_chain_in_n,
    output logic                   read_chain_out_n,
    output logic                   write_chain_out_n,
    output logic                   empty_flag_n,
    output logic                   full_flag_n,
    output logic                   almost_empty_flag_n,
    output logic                   almost_full_flag_n,
    output logic                   half_full_flag_n
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam int SW = DATA_W + 7;

    logic [SW-1:0] pin_raw;
    logic [SW-1:0] pin_s;
    assign pin_raw = {data_in, write_clk, write_enable_n, read_clk, read_enable_n,
                      first_device_select_n, read_chain_in_n, write_chain_in_n};

    sync_2ff #(.W(SW)) u_sync (
        .clk  (clk),
        .rstn (rstn),
        .d    (pin_raw),
        .q    (pin_s)
    );

    wire [DATA_W-1:0] din_s   = pin_s[SW-1:7];
    wire              wclk_s  = pin_s[6];
    wire              wen_n_s = pin_s[5];
    wire              rclk_s  = pin_s[4];
    wire              ren_n_s = pin_s[3];
    wire [2:0]        strap_s = pin_s[2:0];

    logic                  wclk_q, rclk_q, rchain_q, wchain_q;
    logic [1:0]            boot_q;
    fifo_cfg_pkg::mode_t   mode_q;
    logic [PW-1:0]         wptr_q, rptr_q;
    logic [CW-1:0]         count_q;
    logic                  out_valid_q, wtok_q, rtok_q, wtok_out_n_q, rtok_out_n_q;
    logic                  e1_q, e2_q, f1_q, f2_q, ae_sync_q, af_sync_q;
    logic [DATA_W-1:0]     dout_q;
    logic [DATA_W-1:0]     rd_data;
    logic [fifo_cfg_pkg::OFS_W-1:0] ae_q, af_q;
    logic                  empty_n_q, full_n_q, ae_n_q, af_n_q, half_n_q;

    wire w_edge   = wclk_s & ~wclk_q;
    wire r_edge   = rclk_s & ~rclk_q;
    wire wchain_fall = wchain_q & ~strap_s[0];
    wire rchain_fall = rchain_q & ~strap_s[1];
    wire booted   = (boot_q == fifo_cfg_pkg::BOOT_DONE);
    wire capture  = (boot_q == fifo_cfg_pkg::BOOT_CAPTURE);
    wire is_fall  = (mode_q == fifo_cfg_pkg::MODE_FALL);
    wire is_daisy = (mode_q == fifo_cfg_pkg::MODE_DAISY);
    wire full     = (count_q == CW'(DEPTH));
    wire empty    = (count_q == '0);
    wire w_last   = (wptr_q == PW'(DEPTH - 1));
    wire r_last   = (rptr_q == PW'(DEPTH - 1));

    // strap decode; the two codes left over mean a daisy-chain member
    wire strap_fall = (strap_s == fifo_cfg_pkg::STRAP_FALL_A) |
                      (strap_s == fifo_cfg_pkg::STRAP_FALL_B);
    wire strap_dbl  = (strap_s == fifo_cfg_pkg::STRAP_DBL_A) |
                      (strap_s == fifo_cfg_pkg::STRAP_DBL_B);
    wire strap_std  = (strap_s == fifo_cfg_pkg::STRAP_STD_A) |
                      (strap_s == fifo_cfg_pkg::STRAP_STD_B);
    wire strap_single = strap_fall | strap_dbl | strap_std;
    wire fifo_cfg_pkg::mode_t strap_mode = strap_fall ? fifo_cfg_pkg::MODE_FALL :
                                           strap_dbl  ? fifo_cfg_pkg::MODE_DBL  :
                                           strap_std  ? fifo_cfg_pkg::MODE_STD  :
                                                        fifo_cfg_pkg::MODE_DAISY;

    // AXI4-Lite slave
    logic        aw_q, w_q, bvalid_q, rvalid_q;
    logic [7:0]  awaddr_q;
    logic [31:0] wdata_q, rdata_q, rd_mux;
    logic [3:0]  wstrb_q;
    logic [1:0]  bresp_q, rresp_q;

    assign awready = ~aw_q & ~bvalid_q;
    assign wready  = ~w_q & ~bvalid_q;
    assign bvalid  = bvalid_q;
    assign bresp   = bresp_q;
    assign arready = ~rvalid_q;
    assign rvalid  = rvalid_q;
    assign rdata   = rdata_q;
    assign rresp   = rresp_q;

    wire do_wr  = aw_q & w_q & ~bvalid_q;
    wire sel_ae = (awaddr_q == fifo_cfg_pkg::OFF_AE);
    wire sel_af = (awaddr_q == fifo_cfg_pkg::OFF_AF);
    wire sel_ct = (awaddr_q == fifo_cfg_pkg::OFF_CTRL);
    wire wr_hit = sel_ae | sel_af | sel_ct;
    wire flush  = do_wr & sel_ct & wstrb_q[0] & wdata_q[fifo_cfg_pkg::CTRL_FLUSH_BIT];
    wire rd_hit = (araddr == fifo_cfg_pkg::OFF_CTRL) | (araddr == fifo_cfg_pkg::OFF_AE) |
                  (araddr == fifo_cfg_pkg::OFF_AF) | (araddr == fifo_cfg_pkg::OFF_STATUS) |
                  (araddr == fifo_cfg_pkg::OFF_COUNT);

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (araddr)
            fifo_cfg_pkg::OFF_AE:     rd_mux[fifo_cfg_pkg::OFS_W-1:0] = ae_q;
            fifo_cfg_pkg::OFF_AF:     rd_mux[fifo_cfg_pkg::OFS_W-1:0] = af_q;
            fifo_cfg_pkg::OFF_COUNT:  rd_mux[CW-1:0] = count_q;
            fifo_cfg_pkg::OFF_STATUS: begin
                rd_mux[fifo_cfg_pkg::STAT_MODE_LSB +: 4] = mode_q;
                rd_mux[fifo_cfg_pkg::STAT_EMPTY_BIT]     = empty;
                rd_mux[fifo_cfg_pkg::STAT_FULL_BIT]      = full;
                rd_mux[fifo_cfg_pkg::STAT_OUTV_BIT]      = out_valid_q;
                rd_mux[fifo_cfg_pkg::STAT_WTOK_BIT]      = wtok_q;
                rd_mux[fifo_cfg_pkg::STAT_RTOK_BIT]      = rtok_q;
            end
            default:                  rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            aw_q     <= 1'b0;
            w_q      <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q  <= 32'h0000_0000;
            wstrb_q  <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q  <= fifo_cfg_pkg::RESP_OKAY;
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= fifo_cfg_pkg::RESP_OKAY;
            ae_q     <= fifo_cfg_pkg::AE_RESET;
            af_q     <= fifo_cfg_pkg::AF_RESET;
        end else begin
            if (awvalid && awready) begin
                aw_q     <= 1'b1;
                awaddr_q <= awaddr;
            end
            if (wvalid && wready) begin
                w_q     <= 1'b1;
                wdata_q <= wdata;
                wstrb_q <= wstrb;
            end
            if (do_wr) begin
                aw_q     <= 1'b0;
                w_q      <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q  <= wr_hit ? fifo_cfg_pkg::RESP_OKAY : fifo_cfg_pkg::RESP_SLVERR;
                if (sel_ae && wstrb_q[0]) ae_q[7:0] <= wdata_q[7:0];
                if (sel_ae && wstrb_q[1]) ae_q[11:8] <= wdata_q[11:8];
                if (sel_af && wstrb_q[0]) af_q[7:0] <= wdata_q[7:0];
                if (sel_af && wstrb_q[1]) af_q[11:8] <= wdata_q[11:8];
            end else if (bvalid_q && bready) begin
                bvalid_q <= 1'b0;
            end
            if (arvalid && arready) begin
                rvalid_q <= 1'b1;
                rdata_q  <= rd_mux;
                rresp_q  <= rd_hit ? fifo_cfg_pkg::RESP_OKAY : fifo_cfg_pkg::RESP_SLVERR;
            end else if (rvalid_q && rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    // data path: a daisy member moves data only while it holds the token
    wire wr_ev   = booted & w_edge & ~wen_n_s & ~full & (~is_daisy | wtok_q);
    wire std_rd  = booted & r_edge & ~ren_n_s & ~empty & ~is_fall & (~is_daisy | rtok_q);
    // fall-through refills the output stage on a read clock edge when data is stored and the stage is empty or being read
    wire ft_load = booted & r_edge & is_fall & ~empty & (~out_valid_q | ~ren_n_s);
    wire ft_drain = booted & r_edge & is_fall & out_valid_q & ~ren_n_s;
    wire mem_rd  = std_rd | ft_load;
    wire [CW-1:0] count_d = flush ? '0 : CW'(count_q + CW'(wr_ev) - CW'(mem_rd));

    fifo_store #(.W(DATA_W), .D(DEPTH), .AW(PW)) u_store (
        .clk   (clk),
        .we    (wr_ev),
        .waddr (wptr_q),
        .wdata (din_s),
        .raddr (rptr_q),
        .rdata (rd_data)
    );

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wclk_q <= 1'b0;
            rclk_q <= 1'b0;
            rchain_q <= 1'b1;
            wchain_q <= 1'b1;
            boot_q <= 2'h0;
            mode_q <= fifo_cfg_pkg::MODE_STD;
        end else begin
            wclk_q <= wclk_s;
            rclk_q <= rclk_s;
            rchain_q <= strap_s[1];
            wchain_q <= strap_s[0];
            if (!booted) boot_q <= boot_q + 2'h1;
            if (capture) mode_q <= strap_mode;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wptr_q      <= '0;
            rptr_q      <= '0;
            count_q     <= '0;
            out_valid_q <= 1'b0;
            dout_q      <= '0;
        end else begin
            count_q <= count_d;
            if (flush) begin
                wptr_q      <= '0;
                rptr_q      <= '0;
                out_valid_q <= 1'b0;
            end else begin
                if (wr_ev) wptr_q <= w_last ? '0 : PW'(wptr_q + 1'b1);
                if (mem_rd) rptr_q <= r_last ? '0 : PW'(rptr_q + 1'b1);
                if (mem_rd) dout_q <= rd_data;
                if (ft_load) out_valid_q <= 1'b1;
                else if (ft_drain) out_valid_q <= 1'b0;
            end
        end
    end
    assign data_out = dout_q;

    // chain tokens: held out low for one link clock period so a slower neighbour sees it
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wtok_q  <= 1'b0;
            rtok_q  <= 1'b0;
            wtok_out_n_q <= 1'b1;
            rtok_out_n_q <= 1'b1;
        end else begin
            if (capture) begin
                wtok_q <= ~strap_s[2];
                rtok_q <= ~strap_s[2];
            end
            if (w_edge) wtok_out_n_q <= 1'b1;
            if (r_edge) rtok_out_n_q <= 1'b1;
            if (is_daisy && wr_ev && w_last) begin
                wtok_q       <= 1'b0;
                wtok_out_n_q <= 1'b0;
            end
            if (is_daisy && std_rd && r_last) begin
                rtok_q       <= 1'b0;
                rtok_out_n_q <= 1'b0;
            end
            if (booted && is_daisy && wchain_fall) wtok_q <= 1'b1;
            if (booted && is_daisy && rchain_fall) rtok_q <= 1'b1;
        end
    end
    assign write_chain_out_n = wtok_out_n_q;
    assign read_chain_out_n  = rtok_out_n_q;

    // flag stages: assert on the first stage, release only after both in double mode
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            e1_q      <= 1'b1;
            e2_q      <= 1'b1;
            f1_q      <= 1'b0;
            f2_q      <= 1'b0;
            ae_sync_q <= 1'b1;
            af_sync_q <= 1'b0;
        end else begin
            if (r_edge || flush) begin
                e1_q      <= (count_d == '0);
                e2_q      <= e1_q | flush;
                ae_sync_q <= 32'(count_d) <= 32'(ae_q);
            end
            if (w_edge || flush) begin
                f1_q      <= (count_d == CW'(DEPTH));
                f2_q      <= f1_q & ~flush;
                af_sync_q <= 32'(count_d) + 32'(af_q) >= 32'(DEPTH);
            end
        end
    end

    wire ae_async = 32'(count_q) <= 32'(ae_q);
    wire af_async = 32'(count_q) + 32'(af_q) >= 32'(DEPTH);
    logic empty_n_d, full_n_d, ae_d, af_d, half_n_d;

    always_comb begin
        ae_d     = ~ae_sync_q;
        af_d     = ~af_sync_q;
        half_n_d = ~(32'(count_q) > 32'(DEPTH / 2));
        case (mode_q)
            fifo_cfg_pkg::MODE_STD: begin
                empty_n_d = ~e1_q;
                full_n_d  = ~f1_q;
            end
            fifo_cfg_pkg::MODE_DBL: begin
                empty_n_d = ~(e1_q | e2_q);
                full_n_d  = ~(f1_q | f2_q);
            end
            fifo_cfg_pkg::MODE_FALL: begin
                empty_n_d = ~out_valid_q;
                full_n_d  = f1_q;
            end
            fifo_cfg_pkg::MODE_DAISY: begin
                empty_n_d = ~e1_q;
                full_n_d  = ~f1_q;
                ae_d      = ~ae_async;
                af_d      = ~af_async;
                half_n_d  = 1'b1;
            end
            default: begin
                empty_n_d = 1'b0;
                full_n_d  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            empty_n_q <= 1'b0;
            full_n_q  <= 1'b1;
            ae_n_q    <= 1'b0;
            af_n_q    <= 1'b1;
            half_n_q  <= 1'b1;
        end else begin
            empty_n_q <= empty_n_d;
            full_n_q  <= full_n_d;
            ae_n_q    <= ae_d;
            af_n_q    <= af_d;
            half_n_q  <= half_n_d;
        end
    end
    assign empty_flag_n        = empty_n_q;
    assign full_flag_n         = full_n_q;
    assign almost_empty_flag_n = ae_n_q;
    assign almost_full_flag_n  = af_n_q;
    assign half_full_flag_n    = half_n_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_single_mode: assert property (capture && strap_single |=> !is_daisy)
        else $error("single-device strap gave daisy mode");
    a_fall_sel: assert property (capture && strap_fall |=> is_fall)
        else $error("fall-through strap not taken");
    a_dbl_sel: assert property (capture && strap_dbl |=> mode_q == fifo_cfg_pkg::MODE_DBL)
        else $error("double-buffer strap not taken");
    a_depth_bound: assert property (count_q <= CW'(DEPTH))
        else $error("count beyond depth");
    a_half_daisy: assert property (is_daisy && $stable(mode_q) |=> half_full_flag_n)
        else $error("half-full driven in daisy mode");
    a_fall_through: assert property (booted && is_fall && r_edge && !empty && !out_valid_q
                                     |=> out_valid_q ##1 !empty_flag_n)
        else $error("word did not fall through");
    a_ready_low: assert property (is_fall && $rose(out_valid_q) |=> !empty_flag_n)
        else $error("output ready not driven low");
    a_bubble_up: assert property (is_fall && w_edge && !flush && count_d != CW'(DEPTH)
                                  ##1 is_fall |=> !full_flag_n)
        else $error("input ready not low after vacancy");
    a_daisy_async: assert property (is_daisy ##1 is_daisy
                                    |-> almost_empty_flag_n == !$past(ae_async))
        else $error("daisy almost-empty not asynchronous");
endmodule

// [dv/fifo_link_model.sv]
`timescale 1ns/10ps
module fifo_link_model #(
    parameter int W = 18
) (
    output logic         write_clk,
    output logic         write_enable_n,
    output logic [W-1:0] data_in,
    output logic         read_clk,
    output logic         read_enable_n
);
    initial begin
        write_clk = 1'b0;
        write_enable_n = 1'b1;
        data_in = '0;
        forever #40 write_clk = ~write_clk;
    end
    // read clock runs free, otherwise a fall-through word never reaches the outputs
    initial begin
        read_clk = 1'b0;
        read_enable_n = 1'b1;
        #17;
        forever #40 read_clk = ~read_clk;
    end
    // one word every two write clocks; the bus shows the inverse once released
    task automatic push(input logic [W-1:0] w);
        @(negedge write_clk);
        write_enable_n = 1'b0;
        data_in = w;
        @(negedge write_clk);
        write_enable_n = 1'b1;
        data_in = ~w;
    endtask
    task automatic pop();
        @(negedge read_clk);
        read_enable_n = 1'b0;
        @(negedge read_clk);
        read_enable_n = 1'b1;
    endtask
endmodule

// [dv/fifo_expansion_config_bench.sv]
`timescale 1ns/10ps
module fifo_expansion_config_bench;
    localparam int D = 16;
    logic                             clk, rstn, awvalid, wvalid, bready, arvalid, rready;
    logic [7:0]                       awaddr, araddr;
    logic [31:0]                      wdata, rd;
    logic [3:0]                       wstrb;
    logic [1:0]                       rr;
    logic [2:0]                       strap;
    wire logic                        awready, wready, bvalid, arready, rvalid, rclk, wclk;
    wire logic                        wen_n, ren_n, rco_n, wco_n, ae_n, af_n;
    wire logic                        empty_n, full_n, half_n;
    wire logic [1:0]                  bresp, rresp;
    wire logic [31:0]                 rdata;
    wire logic [fifo_cfg_pkg::DATA_W-1:0] din, dout;
    logic [2:0]                       straps [7] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3};
    logic [3:0]                       modes [7] = '{4'h1, 4'h1, 4'h4, 4'h4, 4'h2, 4'h2, 4'h8};
    int                               n_errors = 0;
    int                               checks_done = 0;

    fifo_expansion_config #(.DEPTH(D)) dut (
        .clk(clk), .rstn(rstn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .write_clk(wclk), .write_enable_n(wen_n), .data_in(din), .read_clk(rclk),
        .read_enable_n(ren_n), .data_out(dout), .first_device_select_n(strap[2]),
        .read_chain_in_n(strap[1]), .write_chain_in_n(strap[0]),
        .read_chain_out_n(rco_n), .write_chain_out_n(wco_n), .empty_flag_n(empty_n),
        .full_flag_n(full_n), .almost_empty_flag_n(ae_n), .almost_full_flag_n(af_n),
        .half_full_flag_n(half_n));

    fifo_link_model link (.write_clk(wclk), .write_enable_n(wen_n), .data_in(din),
        .read_clk(rclk), .read_enable_n(ren_n));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic complete_run();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        checks_done++;
        if (s !== e) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask

    // straps must stay put well past release, so they change only under reset
    task automatic reset_with(input logic [2:0] s);
        @(posedge clk);
        rstn <= 1'b0;
        strap <= s;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        repeat (6) @(posedge clk);
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    initial begin
        rstn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, strap} = '0;
        wstrb = 4'hF;
        for (int i = 0; i < 7; i++) begin
            reset_with(straps[i]);
            axi_rd(fifo_cfg_pkg::OFF_STATUS, rd, rr);
            chk("mode", 32'(modes[i]), 32'(rd[3:0]));
        end
        reset_with(fifo_cfg_pkg::STRAP_STD_A);
        chk("empty_flag_n", 32'h0, 32'(empty_n));
        axi_rd(fifo_cfg_pkg::OFF_AE, rd, rr);
        chk("ae_offset", 32'h7, rd);
        axi_rd(8'h40, rd, rr);
        chk("unmapped_resp", 32'(fifo_cfg_pkg::RESP_SLVERR), 32'(rr));
        axi_wr(fifo_cfg_pkg::OFF_STATUS, 32'h0, rr);
        chk("status_write_resp", 32'(fifo_cfg_pkg::RESP_SLVERR), 32'(rr));
        // one word beyond the depth, which must be dropped
        for (int i = 0; i <= D; i++) link.push(18'(i * 3 + 1));
        axi_rd(fifo_cfg_pkg::OFF_COUNT, rd, rr);
        chk("count_full", 32'(D), rd);
        chk("full_flag_n", 32'h0, 32'(full_n));
        chk("half_full_n", 32'h0, 32'(half_n));
        chk("almost_empty_n", 32'h1, 32'(ae_n));
        chk("almost_full_n", 32'h0, 32'(af_n));
        for (int i = 0; i < D; i++) begin
            link.pop();
            chk("data_out", 32'(i * 3 + 1), 32'(dout));
        end
        chk("empty_after", 32'h0, 32'(empty_n));
        reset_with(fifo_cfg_pkg::STRAP_FALL_A);
        link.push(18'h2A5A5);
        repeat (6) @(posedge rclk);
        chk("fall_data", 32'h2A5A5, 32'(dout));
        chk("output_ready_n", 32'h0, 32'(empty_n));
        chk("input_ready_n", 32'h0, 32'(full_n));
        link.push(18'h01357);
        link.pop();
        chk("next_data", 32'h01357, 32'(dout));
        // flush drops the word still standing in the output stage
        axi_wr(fifo_cfg_pkg::OFF_CTRL, 32'h1, rr);
        chk("ctrl_write_resp", 32'(fifo_cfg_pkg::RESP_OKAY), 32'(rr));
        axi_rd(fifo_cfg_pkg::OFF_STATUS, rd, rr);
        chk("flush_out_valid", 32'h0, 32'(rd[fifo_cfg_pkg::STAT_OUTV_BIT]));
        chk("flush_ready_n", 32'h1, 32'(empty_n));
        // first device of a chain: select strapped low, chain inputs idle high
        reset_with(3'h3);
        for (int i = 0; i < D; i++) link.push(18'(i));
        chk("write_chain_out_n", 32'h0, 32'(wco_n));
        chk("chain_half_full_n", 32'h1, 32'(half_n));
        for (int i = 0; i < D; i++) begin
            link.pop();
            chk("chain_data", 32'(i), 32'(dout));
        end
        chk("read_chain_out_n", 32'h0, 32'(rco_n));
        chk("chain_almost_empty_n", 32'h0, 32'(ae_n));
        complete_run();
    end

    initial begin
        #60000;
        n_errors++;
        complete_run();
    end
endmodule
